//--- inc/lcdd_defines.svh
// register addresses, field positions, reset values and timing counts of the lcd driver control
// assumes a 16-bit word address and 4-bit data on the cpu side
`ifndef LCDD_DEFINES_SVH
`define LCDD_DEFINES_SVH

`define LCDD_NSEG 60
`define LCDD_NCOM 4
`define LCDD_NWORD 64

`define LCDD_MEM_BASE 16'hf000
`define LCDD_MEM_LAST 16'hf03f
`define LCDD_CTL0_ADDR 16'hff60
`define LCDD_CTL1_ADDR 16'hff61

`define LCDD_CTL0_RESET 4'h0
`define LCDD_CTL1_RESET 4'h0

`define LCDD_SUPPLY_BIT 0
`define LCDD_SPARE_BIT 1
`define LCDD_DUTY_LO_BIT 2
`define LCDD_DUTY_HI_BIT 3
`define LCDD_STATIC_BIT 0
`define LCDD_LIT_BIT 1
`define LCDD_DARK_BIT 2
`define LCDD_CTL1_MASK 4'h7

`define LCDD_CLK_PERIOD_NS 10
`define LCDD_SLOT_TIME_NS 7812500
`define LCDD_SLOT_CYCLES (`LCDD_SLOT_TIME_NS / `LCDD_CLK_PERIOD_NS)

`endif

//--- inc/lcdd_pkg.sv
// types and the default segment decoder map of the lcd driver control
// assumes lcdd_defines.svh is on the include path
`include "lcdd_defines.svh"

package lcdd_pkg;

	// drive level of a terminal: 0 ground, 1..3 the three generated levels
	typedef logic [1:0] lcdd_lvl_t;

	// one decoder entry: display word in [7:2], bit within the word in [1:0]
	typedef logic [7:0] lcdd_map_t;

	typedef logic [`LCDD_NSEG*`LCDD_NCOM*8-1:0] lcdd_map_vec_t;

	// default decoder: segment s, common c shows word s, bit c
	function automatic lcdd_map_vec_t lcdd_default_map();
		lcdd_map_vec_t m;
		m = '0;
		for (int s = 0; s < `LCDD_NSEG; s++) begin
			for (int c = 0; c < `LCDD_NCOM; c++) begin
				m[(s*`LCDD_NCOM+c)*8 +: 8] = {6'(s), 2'(c)};
			end
		end
		return m;
	endfunction : lcdd_default_map

endpackage : lcdd_pkg

//--- design/lcdd_ctrl.sv
// lcd driver control: display memory, two control words, common/segment drive level sequencing
// assumes a synchronous cpu port with one-cycle strobes and a 100 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
`include "lcdd_defines.svh"

// Behaviour
// - build-time decoder maps any bit of words f000h..f03fh to any segment/common
// - mapped bit one drives segment lit, zero drives it unlit
// - unmapped display bits remain ordinary read-write storage
// - segment pairs may be dc outputs showing their common-zero display bit
// - each dc terminal is push-pull or low-only open drain by build option
// - build option selects 1/3 bias four levels or 1/2 bias three levels
// - supply bit enables drive levels; clear holds all levels at ground
// - supply bit does not affect dc output terminals
// - duty bits select 1/2, 1/3 or 1/4 duty and commons used
// - frame rate 32 Hz at 1/2 and 1/4 duty, 42.7 Hz at 1/3
// - drive-method bit selects static when one, dynamic when zero
// - force-lit bit shows every lcd segment lit without touching memory
// - force-dark bit shows every lcd segment unlit without touching memory
// - force-lit wins over force-dark
// - top bit of the second control word ignores writes, reads zero
// - spare bit of first control word is plain storage
// - reset clears all control bits
// - supply off puts every common and lcd segment terminal at ground
// - static drive lights a segment when any of its four bits is one
// - both common terminal sets carry identical levels
module lcdd_ctrl #(
	parameter int SLOT_CYCLES = `LCDD_SLOT_CYCLES,
	parameter lcdd_pkg::lcdd_map_vec_t SEG_MAP = lcdd_pkg::lcdd_default_map(),
	parameter logic [`LCDD_NSEG/2-1:0] DC_PAIR = '0,
	parameter logic [`LCDD_NSEG-1:0] OPEN_DRAIN = '0,
	parameter bit HALF_BIAS = 1'b0
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [15:0] addr_i,
	input wire logic [3:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [3:0] rdata_o,
	output logic lcd_supply_on_o,
	output logic [2*`LCDD_NCOM-1:0] common_outputs_a_o,
	output logic [2*`LCDD_NCOM-1:0] common_outputs_b_o,
	output logic [2*`LCDD_NSEG-1:0] segment_outputs_o,
	output logic [`LCDD_NSEG-1:0] seg_dc_out_o,
	output logic [`LCDD_NSEG-1:0] seg_dc_oe_o
);
	import lcdd_pkg::*;

	localparam int NSEG = `LCDD_NSEG;
	localparam int NCOM = `LCDD_NCOM;
	localparam int CW = $clog2(SLOT_CYCLES + 1);

	// levels: selected common is the outer level, unselected the inner ones;
	// pol flips every frame so each segment sees zero average voltage
	function automatic lcdd_lvl_t drive_lvl(input logic is_com, input logic on, input logic pol);
		lcdd_lvl_t l;
		if (is_com) begin
			l = on ? (pol ? 2'h3 : 2'h0) : (pol ? 2'h1 : 2'h2);
		end else begin
			l = on ? (pol ? 2'h0 : 2'h3) : (pol ? 2'h2 : 2'h1);
		end
		if (HALF_BIAS && l == 2'h2) begin
			l = 2'h1;
		end
		return l;
	endfunction : drive_lvl

	// display memory is not reset: its contents are undefined until software fills it
	logic [3:0] mem_q [`LCDD_NWORD];
	logic [3:0] ctl0_q;
	logic [3:0] ctl1_q;
	logic [3:0] rdata_q;
	logic [CW-1:0] slot_cnt_q;
	logic half_q;
	logic [1:0] com_q;
	logic pol_q;
	lcdd_lvl_t com_q_lvl [NCOM];
	logic [2*NCOM-1:0] com_lvl_q;
	logic [2*NSEG-1:0] seg_lvl_q;
	logic [NSEG-1:0] dc_out_q;
	logic [NSEG-1:0] dc_oe_q;

	// address decode
	// the whole 64-word window is storage, mapped to a segment or not
	wire sel_mem = addr_i[15:6] == 10'(`LCDD_MEM_BASE >> 6);
	wire sel_c0 = addr_i == `LCDD_CTL0_ADDR;
	wire sel_c1 = addr_i == `LCDD_CTL1_ADDR;
	wire [5:0] mem_idx = addr_i[5:0];
	wire [3:0] rdata_d = sel_mem ? mem_q[mem_idx] : sel_c0 ? ctl0_q : sel_c1 ? ctl1_q : 4'h0;

	// control fields
	wire supply = ctl0_q[`LCDD_SUPPLY_BIT];
	wire duty_sel_high = ctl0_q[`LCDD_DUTY_HI_BIT];
	wire duty_sel_low = ctl0_q[`LCDD_DUTY_LO_BIT];
	wire static_drive_sel = ctl1_q[`LCDD_STATIC_BIT];
	wire force_all_lit = ctl1_q[`LCDD_LIT_BIT];
	wire force_all_dark = ctl1_q[`LCDD_DARK_BIT];
	wire [1:0] last_com = duty_sel_high ? 2'h1 : duty_sel_low ? 2'h2 : 2'h3;

	// frame timing: one slot per 128 Hz tick; 1/2 duty holds each common two ticks
	wire tick = slot_cnt_q == CW'(SLOT_CYCLES - 1);
	wire step = tick & (~duty_sel_high | half_q);
	wire frame_end = step & (com_q >= last_com);

	// control words reset to zero: unpowered, quarter duty, dynamic, normal display
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			ctl0_q <= `LCDD_CTL0_RESET;
			ctl1_q <= `LCDD_CTL1_RESET;
		end else if (wr_i && sel_c0) begin
			ctl0_q <= wdata_i;
		end else if (wr_i && sel_c1) begin
			ctl1_q <= wdata_i & `LCDD_CTL1_MASK;
		end
	end

	// no reset on purpose: software clears the words anyway, a hardware clear would cost a loop
	always_ff @(posedge ref_clk_i) begin
		if (wr_i && sel_mem) begin
			mem_q[mem_idx] <= wdata_i;
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			rdata_q <= 4'h0;
		end else begin
			rdata_q <= rd_i ? rdata_d : 4'h0;
		end
	end

	// free-running, so the frame phase does not depend on when the supply came on
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			slot_cnt_q <= '0;
			half_q <= 1'b0;
		end else begin
			slot_cnt_q <= tick ? '0 : slot_cnt_q + CW'(1);
			half_q <= tick ? ~half_q : half_q;
		end
	end

	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			com_q <= 2'h0;
			pol_q <= 1'b0;
		end else if (step) begin
			com_q <= frame_end ? 2'h0 : com_q + 2'h1;
			pol_q <= frame_end ? ~pol_q : pol_q;
		end
	end

	// segment decoder and segment levels
	logic [NCOM-1:0] seg_bits [NSEG];
	logic [2*NSEG-1:0] seg_lvl_d;
	logic [NSEG-1:0] dc_out_d;
	logic [NSEG-1:0] dc_oe_d;

	for (genvar s = 0; s < NSEG; s++) begin : g_seg
		for (genvar c = 0; c < NCOM; c++) begin : g_bit
			localparam lcdd_map_t ENT = SEG_MAP[(s*NCOM+c)*8 +: 8];
			assign seg_bits[s][c] = mem_q[ENT[7:2]][ENT[1:0]];
		end
		wire shown = static_drive_sel ? |seg_bits[s] : seg_bits[s][com_q];
		wire on = force_all_lit | (~force_all_dark & shown);
		// in static drive an unlit segment copies the common, so the glass sees zero volts
		wire lcdd_lvl_t lvl = static_drive_sel ? drive_lvl(~on, 1'b1, pol_q) : drive_lvl(1'b0, on, pol_q);
		wire is_dc = DC_PAIR[s/2];
		wire dc_bit = seg_bits[s][0];
		assign seg_lvl_d[2*s +: 2] = (supply && !is_dc) ? lvl : 2'h0;
		// dc terminals ignore supply and force bits, they just mirror the common-zero bit
		assign dc_out_d[s] = is_dc & ~OPEN_DRAIN[s] & dc_bit;
		assign dc_oe_d[s] = is_dc & (OPEN_DRAIN[s] ? ~dc_bit : 1'b1);
	end

	// common levels; unused commons in 1/2 and 1/3 duty stay unselected
	logic [2*NCOM-1:0] com_lvl_d;
	for (genvar c = 0; c < NCOM; c++) begin : g_com
		wire sel_now = static_drive_sel | (com_q == 2'(c));
		assign com_q_lvl[c] = drive_lvl(1'b1, sel_now, pol_q);
		assign com_lvl_d[2*c +: 2] = supply ? com_q_lvl[c] : 2'h0;
	end

	// one register stage on every terminal keeps decoder glitches off the pins
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			com_lvl_q <= '0;
			seg_lvl_q <= '0;
			dc_out_q <= '0;
			dc_oe_q <= '0;
		end else begin
			com_lvl_q <= com_lvl_d;
			seg_lvl_q <= seg_lvl_d;
			dc_out_q <= dc_out_d;
			dc_oe_q <= dc_oe_d;
		end
	end

	// the generator enable is registered too, so it lines up with the first live levels
	logic supply_q;
	always_ff @(posedge ref_clk_i) begin
		if (rst_i) begin
			supply_q <= 1'b0;
		end else begin
			supply_q <= supply;
		end
	end

	assign rdata_o = rdata_q;
	assign lcd_supply_on_o = supply_q;
	assign common_outputs_a_o = com_lvl_q;
	assign common_outputs_b_o = com_lvl_q;
	assign segment_outputs_o = seg_lvl_q;
	assign seg_dc_out_o = dc_out_q;
	assign seg_dc_oe_o = dc_oe_q;

	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (rst_i);

	reset_clears_a: assert property (@(posedge ref_clk_i) disable iff (1'b0)
		rst_i |=> ctl0_q == 4'h0 && ctl1_q == 4'h0 && common_outputs_a_o == '0 && segment_outputs_o == '0)
		else $error("control or outputs not cleared by reset");

	supply_off_gnd_a: assert property (!supply |=> common_outputs_a_o == '0 && segment_outputs_o == '0)
		else $error("drive level present while supply is off");

	com_sets_equal_a: assert property (common_outputs_a_o == common_outputs_b_o)
		else $error("common terminal sets differ");

	ctl1_top_zero_a: assert property (rd_i && sel_c1 |=> rdata_o[3] == 1'b0 && rdata_o[2:0] == $past(ctl1_q[2:0]))
		else $error("second control word read back wrong");

	ctl0_readback_a: assert property (wr_i && sel_c0 ##1 rd_i && sel_c0 |=> rdata_o == $past(wdata_i, 2))
		else $error("first control word did not read back as written");

	mem_readback_a: assert property (wr_i && sel_mem ##1 rd_i && sel_mem && addr_i == $past(addr_i) |=> rdata_o == $past(wdata_i, 2))
		else $error("display word did not read back as written");

	duty_range_a: assert property (step |=> com_q <= $past(last_com))
		else $error("common index beyond selected duty");

	frame_pol_a: assert property (frame_end |=> pol_q != $past(pol_q))
		else $error("polarity did not reverse at frame end");

	slot_len_a: assert property (tick |=> slot_cnt_q == '0 ##1 !tick)
		else $error("slot counter not restarted");

	half_bias_a: assert property (!HALF_BIAS || (common_outputs_a_o[1:0] != 2'h2 && segment_outputs_o[1:0] != 2'h2))
		else $error("middle level seen with half bias");

	// register side: what is written is what the control logic acts on
	ctl0_write_a: assert property (wr_i && sel_c0 |=> ctl0_q == $past(wdata_i))
		else $error("first control word not written");

	ctl1_write_a: assert property (wr_i && sel_c1 |=> ctl1_q == ($past(wdata_i) & 4'h7))
		else $error("second control word not written with its top bit cleared");

	ctl_hold_a: assert property (!wr_i |=> $stable(ctl0_q) && $stable(ctl1_q))
		else $error("control word changed without a write");

	mem_write_a: assert property (wr_i && sel_mem |=> mem_q[$past(mem_idx)] == $past(wdata_i))
		else $error("display word not written");

	supply_track_a: assert property (lcd_supply_on_o == $past(supply))
		else $error("supply enable output does not follow its bit");

	// frame sequencing: one common per slot (two slots each at 1/2 duty), wrap with a polarity flip
	slot_bound_a: assert property (slot_cnt_q <= CW'(SLOT_CYCLES - 1))
		else $error("slot counter ran past its end");

	half_toggle_a: assert property (tick |=> half_q != $past(half_q))
		else $error("half-slot phase did not toggle");

	half_step_a: assert property (tick && duty_sel_high && !half_q |=> $stable(com_q))
		else $error("half duty stepped after a single slot");

	com_order_a: assert property (step && !frame_end |=> com_q == $past(com_q) + 2'h1)
		else $error("common index did not advance by one");

	frame_wrap_a: assert property (frame_end |=> com_q == 2'h0)
		else $error("common index did not wrap at frame end");

	pol_hold_a: assert property (step && !frame_end |=> pol_q == $past(pol_q))
		else $error("polarity changed inside a frame");

	// common terminals: the selected one sits at the outer level of this frame
	com_sel_a: assert property (supply && !static_drive_sel
		|=> common_outputs_a_o[2*$past(com_q) +: 2] == ($past(pol_q) ? 2'h3 : 2'h0))
		else $error("selected common not at the outer level");

	com_live_a: assert property (supply && !static_drive_sel |=> common_outputs_a_o != 8'h00)
		else $error("commons flat although the supply is on");

	static_com_a: assert property (supply && static_drive_sel
		|=> common_outputs_a_o[1:0] == common_outputs_a_o[3:2]
		&& common_outputs_a_o[1:0] == common_outputs_a_o[5:4]
		&& common_outputs_a_o[1:0] == common_outputs_a_o[7:6])
		else $error("static drive commons differ");

	for (genvar c = 0; c < NCOM; c++) begin : g_com_chk
		com_unsel_a: assert property (supply && !static_drive_sel && com_q != 2'(c)
			|=> common_outputs_a_o[2*c +: 2] == drive_lvl(1'b1, 1'b0, $past(pol_q)))
			else $error("unselected common not at an inner level");
	end

	// per-terminal checks split by how the terminal was configured at build time
	for (genvar s = 0; s < NSEG; s++) begin : g_chk
		if (!DC_PAIR[s/2]) begin : g_lcd
			force_lit_a: assert property (supply && force_all_lit && !static_drive_sel
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b1, $past(pol_q)))
				else $error("forced lit segment not lit");
			force_dark_a: assert property (supply && force_all_dark && !force_all_lit && !static_drive_sel
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b0, $past(pol_q)))
				else $error("forced dark segment not dark");

			lit_dyn_a: assert property (supply && !static_drive_sel && !force_all_dark && seg_bits[s][com_q]
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b1, $past(pol_q)))
				else $error("segment with a set bit not lit");

			dark_dyn_a: assert property (supply && !static_drive_sel && !force_all_lit && !seg_bits[s][com_q]
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b0, $past(pol_q)))
				else $error("segment with a clear bit lit");

			static_lit_a: assert property (supply && static_drive_sel && !force_all_dark && seg_bits[s] != 4'h0
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b1, $past(pol_q)))
				else $error("static segment with a set bit not lit");

			static_force_a: assert property (supply && static_drive_sel && force_all_lit
				|=> segment_outputs_o[2*s +: 2] == drive_lvl(1'b0, 1'b1, $past(pol_q)))
				else $error("forced lit static segment not lit");

			static_dark_a: assert property (supply && static_drive_sel && !force_all_lit
				&& (force_all_dark || seg_bits[s] == 4'h0)
				|=> segment_outputs_o[2*s +: 2] == common_outputs_a_o[1:0])
				else $error("static unlit segment differs from the common");

			lcd_no_dc_a: assert property (seg_dc_oe_o[s] == 1'b0 && seg_dc_out_o[s] == 1'b0)
				else $error("lcd terminal drives its dc output");
		end else begin : g_dc
			// the first cycle after reset still shows the cleared registers
			dc_follow_a: assert property ($past(!rst_i) |->
				seg_dc_oe_o[s] == (OPEN_DRAIN[s] ? ~$past(seg_bits[s][0]) : 1'b1)
				&& seg_dc_out_o[s] == (~OPEN_DRAIN[s] & $past(seg_bits[s][0]))
				&& segment_outputs_o[2*s +: 2] == 2'h0)
				else $error("dc terminal does not follow its bit");
		end
	end

	static_run_c: cover property (supply && static_drive_sel && frame_end);
	third_duty_c: cover property (supply && !duty_sel_high && duty_sel_low && frame_end);
	half_duty_c: cover property (supply && duty_sel_high && frame_end);
	force_both_c: cover property (supply && force_all_lit && force_all_dark);
	quarter_duty_c: cover property (supply && !duty_sel_high && !duty_sel_low && frame_end);

endmodule : lcdd_ctrl
`default_nettype wire

//--- tb/lcdd_panel_model.sv
// passive glass model: a segment shows when it sees a full three-step swing against some common
// assumes the level codes of the driver, 0 ground up to 3 the top level, and 1/3 bias
`timescale 1ns/1ps
`default_nettype none
module lcdd_panel_model (
	input wire logic [7:0] com_i,
	input wire logic [119:0] seg_i,
	output logic [59:0] lit_o
);
	// unselected commons sit one step from either segment level, so only a selected one lights
	always_comb begin
		lit_o = '0;
		for (int s = 0; s < 60; s++) begin
			for (int c = 0; c < 4; c++) begin
				if ({com_i[2*c+:2], seg_i[2*s+:2]} == 4'h3 || {com_i[2*c+:2], seg_i[2*s+:2]} == 4'hc) begin
					lit_o[s] = 1'b1;
				end
			end
		end
	end
endmodule : lcdd_panel_model
`default_nettype wire

//--- tb/test_lcd_segment_driver_control.sv
// register-port tests of the lcd driver control, judged through a glass model
// assumes an 8-cycle slot, pair 29 as dc output and terminal 59 open drain
`timescale 1ns/1ps
`default_nettype none
module test_lcd_segment_driver_control;
	logic ref_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [15:0] addr_i = 16'h0000;
	logic [3:0] wdata_i = 4'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [3:0] rdata_o;
	logic lcd_supply_on_o;
	logic [7:0] com_a;
	logic [7:0] com_b;
	logic [119:0] seg;
	logic [59:0] dc_out;
	logic [59:0] dc_oe;
	logic [59:0] lit;
	int n_errors = 0;
	int check_count = 0;

	always #5 ref_clk_i = ~ref_clk_i;

	lcdd_ctrl #(.SLOT_CYCLES(8), .DC_PAIR(30'h20000000), .OPEN_DRAIN(60'h800000000000000)) i_dut (
		.ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .lcd_supply_on_o(lcd_supply_on_o), .common_outputs_a_o(com_a),
		.common_outputs_b_o(com_b), .segment_outputs_o(seg), .seg_dc_out_o(dc_out), .seg_dc_oe_o(dc_oe)
	);
	lcdd_panel_model i_panel (.com_i(com_a), .seg_i(seg), .lit_o(lit));

	task automatic chk(input logic [15:0] s, input logic [15:0] e);
		check_count++;
		if (s !== e) begin
			n_errors++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, s, e);
		end
	endtask : chk

	task automatic wr(input logic [15:0] a, input logic [3:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
	endtask : wr

	task automatic rd(input logic [15:0] a, input logic [3:0] e);
		@(posedge ref_clk_i);
		addr_i <= a;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(16'(rdata_o), 16'(e));
	endtask : rd

	// write then read back with no idle cycle between the strobes
	task automatic wrrd(input logic [15:0] a, input logic [3:0] d);
		@(posedge ref_clk_i);
		addr_i <= a;
		wdata_i <= d;
		wr_i <= 1'b1;
		@(posedge ref_clk_i);
		wr_i <= 1'b0;
		rd_i <= 1'b1;
		@(posedge ref_clk_i);
		rd_i <= 1'b0;
		#1;
		chk(16'(rdata_o), 16'(d));
	endtask : wrrd

	// two frames of segments 0 and 1 against masks per selected common; hi counts com0 at top level
	task automatic watch(input int cyc, input logic [3:0] m0, input logic [3:0] m1, input int hi);
		int nh;
		int sel;
		nh = 0;
		repeat (64) @(posedge ref_clk_i);
		repeat (cyc) begin
			@(posedge ref_clk_i);
			#1;
			sel = 0;
			for (int c = 3; c >= 0; c--) begin
				if (com_a[2*c+:2] == 2'h0 || com_a[2*c+:2] == 2'h3) sel = c;
			end
			if (com_a[1:0] == 2'h3) nh++;
			chk({lit[1:0], com_b}, {m1[sel], m0[sel], com_a});
		end
		chk(16'(nh), 16'(hi));
	endtask : watch

	task automatic results;
		$display("checks %0d errors %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : results

	initial begin
		// the dc pair's words are filled under reset, so its outputs are never unknown
		wr(16'hf03a, 4'h0);
		wr(16'hf03b, 4'h0);
		repeat (2) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		rd(16'hff60, 4'h0);
		rd(16'hff61, 4'h0);
		for (int w = 0; w < 64; w++) wr(16'hf000 + 16'(w), 4'h0);
		$display("test reset done");
		wr(16'hff61, 4'hf);
		rd(16'hff61, 4'h7);
		wrrd(16'hff60, 4'h2);
		wrrd(16'hf03e, 4'h9);
		wr(16'hff62, 4'h5);
		rd(16'hff62, 4'h0);
		wr(16'hff61, 4'h0);
		wr(16'hff60, 4'h0);
		$display("test registers done");
		wr(16'hf03a, 4'h1);
		wr(16'hf03b, 4'h1);
		repeat (3) @(posedge ref_clk_i);
		#1;
		chk({dc_oe[59:58], dc_out[59:58]}, 16'h5);
		chk({lcd_supply_on_o, |com_a, |com_b, |seg}, 16'h0);
		$display("test supply off done");
		wr(16'hf000, 4'h1);
		wr(16'hf001, 4'h2);
		wr(16'hff60, 4'h1);
		rd(16'hff60, 4'h1);
		chk(16'(lcd_supply_on_o), 16'h1);
		watch(64, 4'h1, 4'h2, 8);
		wr(16'hff60, 4'h5);
		watch(48, 4'h1, 4'h2, 8);
		wr(16'hff60, 4'hd);
		watch(64, 4'h1, 4'h2, 16);
		wr(16'hff60, 4'h1);
		wr(16'hff61, 4'h2);
		watch(64, 4'hf, 4'hf, 8);
		rd(16'hf000, 4'h1);
		wr(16'hff61, 4'h4);
		watch(64, 4'h0, 4'h0, 8);
		wr(16'hff61, 4'h6);
		watch(64, 4'hf, 4'hf, 8);
		wr(16'hf001, 4'h0);
		wr(16'hff61, 4'h1);
		watch(64, 4'hf, 4'h0, 32);
		chk({dc_oe[59:58], dc_out[59:58]}, 16'h5);
		$display("test drive done");
		results();
	end

	initial begin
		repeat (6000) @(posedge ref_clk_i);
		n_errors++;
		results();
	end
endmodule : test_lcd_segment_driver_control
`default_nettype wire
